/* shared/frc_pkg.sv */
/*
 * frc_pkg: register addresses, field positions, reset values and memory
 * map constants for the low-memory remap and flash status/mode block.
 * Assumes a 32-bit byte-addressed core address space.
 */
package frc_pkg;

    // register byte addresses
    localparam logic [31:0] REMAP_ADDR   = 32'hffff0220;
    localparam logic [31:0] STA_ADDR     = 32'hffff0e00;
    localparam logic [31:0] MOD_ADDR     = 32'hffff0e04;

    // remap register
    localparam int          REMAP_SEL    = 0;
    localparam logic [7:0]  REMAP_RST    = 8'h00;

    // status register fields
    localparam int          STA_PASS     = 0;
    localparam int          STA_FAIL     = 1;
    localparam int          STA_BUSY     = 2;
    localparam int          STA_IRQ      = 3;
    localparam logic [15:0] STA_RST      = 16'h0020;

    // mode register fields; bits above 8 read zero
    localparam int          MOD_EW_EN    = 3;
    localparam int          MOD_IRQ_EN   = 4;
    localparam logic [15:0] MOD_RST      = 16'h0000;
    localparam logic [15:0] MOD_MASK     = 16'h01ff;

    // memory map
    localparam logic [31:0] RESET_VEC    = 32'h00000000;
    localparam logic [31:0] LOW_WIN_SIZE = 32'h00007800;
    localparam logic [31:0] FLASH_BASE   = 32'h00080000;
    localparam logic [31:0] FLASH_SIZE   = 32'h00008000;
    localparam logic [31:0] KERNEL_OFF   = 32'h00007800;
    localparam logic [31:0] SRAM_BASE    = 32'h00040000;
    localparam logic [31:0] SRAM_SIZE    = 32'h00001000;
    localparam logic [31:0] MMR_BASE     = 32'hffff0000;

    // flash array geometry: 512-byte erase pages
    localparam int          OFF_W        = 15;
    localparam int          PAGE_LSB     = 9;
    localparam int          PAGE_W       = OFF_W - PAGE_LSB;

    typedef enum logic [2:0] {
        BOOT_KERNEL = 3'b001,
        BOOT_VECTOR = 3'b010,
        BOOT_RUN    = 3'b100
    } frc_boot_t;

endpackage : frc_pkg

/* src/frc_sticky_flag.sv */
/*
 * frc_sticky_flag: one status flag set by hardware, cleared by a read.
 * Assumes set and clear are single-cycle strobes on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module frc_sticky_flag (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // strobes
    input  wire logic set_i,
    input  wire logic clr_i,
    // flag
    output logic      q_o
);

    typedef struct packed {
        logic flag;
    } frc_flag_t;

    frc_flag_t st_q;
    frc_flag_t st_d;

    // set beats clear so an event landing on the read is kept
    always_comb begin
        st_d = st_q;
        if (clr_i) begin
            st_d.flag = 1'b0;
        end
        if (set_i) begin
            st_d.flag = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.flag;

endmodule : frc_sticky_flag

`default_nettype wire

/* src/frc_map_decode.sv */
/*
 * frc_map_decode: combinational address decode of the core address space,
 * with the low window steered to flash or SRAM by the remap bit.
 * Assumes memory-mapped registers above MMR_BASE are decoded elsewhere.
 */
`timescale 1ns/10ps
`default_nettype none

module frc_map_decode (
    // request
    input  wire logic [31:0]               addr_i,
    input  wire logic                      remap_i,
    input  wire logic                      kernel_i,
    // decode
    output logic                           flash_hit_o,
    output logic                           sram_hit_o,
    output logic                           abort_o,
    output logic [frc_pkg::OFF_W-1:0]      off_o
);

    logic [31:0] fl_off;
    logic [31:0] sr_off;

    assign fl_off = addr_i - frc_pkg::FLASH_BASE;
    assign sr_off = addr_i - frc_pkg::SRAM_BASE;

    always_comb begin
        flash_hit_o = 1'b0;
        sram_hit_o  = 1'b0;
        abort_o     = 1'b0;
        off_o       = addr_i[frc_pkg::OFF_W-1:0];
        if (addr_i < frc_pkg::LOW_WIN_SIZE) begin
            if (remap_i) begin
                // only 4 kB of SRAM behind a 30 kB window
                sram_hit_o = (addr_i < frc_pkg::SRAM_SIZE);
                abort_o    = (addr_i >= frc_pkg::SRAM_SIZE);
            end else begin
                flash_hit_o = 1'b1;
            end
        end else if (addr_i >= frc_pkg::FLASH_BASE &&
                     fl_off < frc_pkg::FLASH_SIZE) begin
            off_o = fl_off[frc_pkg::OFF_W-1:0];
            if (fl_off >= frc_pkg::KERNEL_OFF && !kernel_i) begin
                abort_o = 1'b1;
            end else begin
                flash_hit_o = 1'b1;
            end
        end else if (addr_i >= frc_pkg::SRAM_BASE &&
                     sr_off < frc_pkg::SRAM_SIZE) begin
            sram_hit_o = 1'b1;
            off_o      = sr_off[frc_pkg::OFF_W-1:0];
        end else if (addr_i < frc_pkg::MMR_BASE) begin
            abort_o = 1'b1;
        end
    end

endmodule : frc_map_decode

`default_nettype wire

/* src/frc_remap_status.sv */
/*
 * frc_remap_status: boot sequencing through the hidden kernel, low-memory
 * remap, flash controller status flags and mode register.
 * Assumes a single-cycle register port from the core, a flash command
 * engine that reports busy, done and pass, and synchronous inputs.
 */
`timescale 1ns/10ps
`default_nettype none

module frc_remap_status (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         srst_i,
    // register port
    input  wire logic                         reg_req_i,
    input  wire logic                         reg_we_i,
    input  wire logic [31:0]                  reg_addr_i,
    input  wire logic [31:0]                  reg_wdata_i,
    output logic      [31:0]                  reg_rdata_o,
    output logic                              reg_ack_o,
    // boot sequencing
    input  wire logic                         kernel_done_i,
    output logic                              kernel_run_o,
    output logic                              core_start_o,
    output logic      [31:0]                  core_pc_o,
    // core memory decode
    input  wire logic                         cpu_valid_i,
    input  wire logic [31:0]                  cpu_addr_i,
    output logic                              flash_sel_o,
    output logic                              sram_sel_o,
    output logic                              abort_o,
    output logic      [frc_pkg::OFF_W-1:0]    mem_off_o,
    output logic      [frc_pkg::PAGE_W-1:0]   page_o,
    // flash command engine
    input  wire logic                         cmd_req_i,
    input  wire logic                         cmd_ew_i,
    input  wire logic                         ctrl_busy_i,
    input  wire logic                         cmd_done_i,
    input  wire logic                         cmd_pass_i,
    output logic                              cmd_go_o,
    output logic                              flash_irq_o
);

    typedef struct packed {
        frc_pkg::frc_boot_t          boot;
        logic                        remap;
        logic [15:0]                 mode;
        logic [31:0]                 rdata;
        logic                        ack;
        logic                        kernel_run;
        logic                        core_start;
        logic                        flash_sel;
        logic                        sram_sel;
        logic                        abort;
        logic [frc_pkg::OFF_W-1:0]   off;
        logic                        cmd_go;
        logic                        irq;
        logic [31:0]                 pc;
    } frc_state_t;

    frc_state_t st_q;
    frc_state_t st_d;

    logic                      hit_remap;
    logic                      hit_sta;
    logic                      hit_mod;
    logic                      sta_rd;
    logic                      refused;
    logic                      pass_q;
    logic                      fail_q;
    logic                      irqf_q;
    logic                      dec_flash;
    logic                      dec_sram;
    logic                      dec_abort;
    logic [frc_pkg::OFF_W-1:0] dec_off;
    logic [15:0]               sta_val;

    assign hit_remap = reg_req_i && reg_addr_i == frc_pkg::REMAP_ADDR;
    assign hit_sta   = reg_req_i && reg_addr_i == frc_pkg::STA_ADDR;
    assign hit_mod   = reg_req_i && reg_addr_i == frc_pkg::MOD_ADDR;
    assign sta_rd    = hit_sta && !reg_we_i;
    // an erase or write asked for while protected is failed, not run
    assign refused   = cmd_req_i && cmd_ew_i &&
                       !st_q.mode[frc_pkg::MOD_EW_EN];

    frc_sticky_flag u_pass (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .set_i  (cmd_done_i && cmd_pass_i),
        .clr_i  (sta_rd),
        .q_o    (pass_q)
    );

    frc_sticky_flag u_fail (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .set_i  ((cmd_done_i && !cmd_pass_i) || refused),
        .clr_i  (sta_rd),
        .q_o    (fail_q)
    );

    frc_sticky_flag u_irqf (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .set_i  (cmd_done_i && st_q.mode[frc_pkg::MOD_IRQ_EN]),
        .clr_i  (sta_rd),
        .q_o    (irqf_q)
    );

    frc_map_decode u_dec (
        .addr_i      (cpu_addr_i),
        .remap_i     (st_q.remap),
        .kernel_i    (st_q.boot == frc_pkg::BOOT_KERNEL),
        .flash_hit_o (dec_flash),
        .sram_hit_o  (dec_sram),
        .abort_o     (dec_abort),
        .off_o       (dec_off)
    );

    // flags as they stand before this read
    always_comb begin
        sta_val                   = frc_pkg::STA_RST;
        sta_val[frc_pkg::STA_PASS] = pass_q;
        sta_val[frc_pkg::STA_FAIL] = fail_q;
        sta_val[frc_pkg::STA_BUSY] = ctrl_busy_i;
        sta_val[frc_pkg::STA_IRQ]  = irqf_q;
    end

    always_comb begin
        st_d            = st_q;
        st_d.ack        = reg_req_i && (hit_remap || hit_sta || hit_mod);
        st_d.rdata      = 32'h00000000;
        st_d.core_start = 1'b0;
        // boot: kernel first, then one start strobe at the vector
        unique case (st_q.boot)
            frc_pkg::BOOT_KERNEL: begin
                if (kernel_done_i) begin
                    st_d.boot = frc_pkg::BOOT_VECTOR;
                end
            end
            frc_pkg::BOOT_VECTOR: begin
                st_d.boot       = frc_pkg::BOOT_RUN;
                st_d.core_start = 1'b1;
            end
            frc_pkg::BOOT_RUN: begin
                st_d.boot = frc_pkg::BOOT_RUN;
            end
            default: begin
                st_d.boot = frc_pkg::BOOT_KERNEL;
            end
        endcase
        st_d.kernel_run = (st_d.boot == frc_pkg::BOOT_KERNEL);
        if (hit_remap) begin
            if (reg_we_i) begin
                // reserved bits 7:1 are not stored and read zero
                st_d.remap = reg_wdata_i[frc_pkg::REMAP_SEL];
            end else begin
                st_d.rdata[frc_pkg::REMAP_SEL] = st_q.remap;
            end
        end
        if (hit_mod) begin
            if (reg_we_i) begin
                st_d.mode = reg_wdata_i[15:0] & frc_pkg::MOD_MASK;
            end else begin
                st_d.rdata[15:0] = st_q.mode;
            end
        end
        // writes to status fall through untouched
        if (sta_rd) begin
            st_d.rdata[15:0] = sta_val;
        end
        st_d.flash_sel = cpu_valid_i && dec_flash;
        st_d.sram_sel  = cpu_valid_i && dec_sram;
        st_d.abort     = cpu_valid_i && dec_abort;
        st_d.off       = dec_off;
        st_d.cmd_go    = cmd_req_i && !refused;
        st_d.irq       = irqf_q && st_q.mode[frc_pkg::MOD_IRQ_EN];
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q            <= '0;
            st_q.boot       <= frc_pkg::BOOT_KERNEL;
            st_q.remap      <= frc_pkg::REMAP_RST[frc_pkg::REMAP_SEL];
            st_q.mode       <= frc_pkg::MOD_RST;
            st_q.kernel_run <= 1'b1;
            st_q.pc         <= frc_pkg::RESET_VEC;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o  = st_q.rdata;
    assign reg_ack_o    = st_q.ack;
    assign kernel_run_o = st_q.kernel_run;
    assign core_start_o = st_q.core_start;
    assign core_pc_o    = st_q.pc;
    assign flash_sel_o  = st_q.flash_sel;
    assign sram_sel_o   = st_q.sram_sel;
    assign abort_o      = st_q.abort;
    assign mem_off_o    = st_q.off;
    // page index from the byte offset within the array
    assign page_o       = st_q.off[frc_pkg::OFF_W-1:frc_pkg::PAGE_LSB];
    assign cmd_go_o     = st_q.cmd_go;
    assign flash_irq_o  = st_q.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_kernel_end;
        st_q.boot == frc_pkg::BOOT_KERNEL && kernel_done_i;
    endsequence

    sequence s_start_once;
        !core_start_o ##1 core_start_o ##1 !core_start_o && !kernel_run_o;
    endsequence

    a_boot_order: assert property (
        s_kernel_end |=> s_start_once)
        else $error("start strobe did not follow kernel end");

    a_remap_reset: assert property (
        $past(srst_i) |-> !st_q.remap && kernel_run_o)
        else $error("reset did not restore flash at zero");

    a_remap_write: assert property (
        hit_remap && reg_we_i |=> st_q.remap == $past(reg_wdata_i[0]))
        else $error("remap bit not taken from write");

    a_sram_low: assert property (
        cpu_valid_i && cpu_addr_i < frc_pkg::SRAM_SIZE && st_q.remap
        |=> sram_sel_o && !flash_sel_o)
        else $error("remapped low access not steered to sram");

    a_kernel_hide: assert property (
        cpu_valid_i && st_q.boot == frc_pkg::BOOT_RUN &&
        cpu_addr_i >= frc_pkg::FLASH_BASE + frc_pkg::KERNEL_OFF &&
        cpu_addr_i <  frc_pkg::FLASH_BASE + frc_pkg::FLASH_SIZE
        |=> abort_o && !flash_sel_o)
        else $error("user access reached kernel region");

    a_page_index: assert property (
        flash_sel_o |-> page_o == $past(cpu_addr_i[14:9]))
        else $error("page index not offset divided by 512");

    a_irq_flag: assert property (
        cmd_done_i && st_q.mode[4] |=> irqf_q ##1 flash_irq_o || !st_q.mode[4])
        else $error("enabled completion did not raise irq");

    a_busy_read: assert property (
        sta_rd |=> reg_ack_o && reg_rdata_o[2] == $past(ctrl_busy_i))
        else $error("busy bit does not follow controller");

    a_fail_clear: assert property (
        sta_rd && !cmd_done_i && !refused |=> !fail_q)
        else $error("fail flag survived status read");

    a_pass_set: assert property (
        cmd_done_i && cmd_pass_i |=> pass_q)
        else $error("pass flag not set on success");

    a_irq_gate: assert property (
        flash_irq_o |-> $past(st_q.mode[4]) && $past(irqf_q))
        else $error("interrupt raised while disabled");

    a_ew_protect: assert property (
        cmd_req_i && cmd_ew_i && !st_q.mode[3] |=> !cmd_go_o && fail_q)
        else $error("protected erase or write was let through");

    a_sta_write: assert property (
        hit_sta && reg_we_i && !cmd_done_i && !refused
        |=> $stable(pass_q) && $stable(fail_q) && $stable(irqf_q))
        else $error("status write changed a flag");

    a_read_old: assert property (
        sta_rd |=> reg_rdata_o[1:0] == $past({fail_q, pass_q}) &&
                   reg_rdata_o[5] == 1'b1)
        else $error("status read did not return prior flags");

endmodule : frc_remap_status

`default_nettype wire

/* verif/frc_remap_status_bench.sv */
/*
 * frc_remap_status_bench: directed bench for boot, low-memory remap,
 * address decode and flash status/mode registers.
 * Assumes the single-cycle register port and one 25 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module frc_remap_status_bench;
    // clock and reset
    logic        clk_i         = 1'b0;
    logic        srst_i        = 1'b1;
    // register port
    logic        reg_req_i     = 1'b0;
    logic        reg_we_i      = 1'b0;
    logic [31:0] reg_addr_i    = 32'h00000000;
    logic [31:0] reg_wdata_i   = 32'h00000000;
    logic [31:0] reg_rdata_o;
    logic        reg_ack_o;
    // boot
    logic        kernel_done_i = 1'b0;
    logic        kernel_run_o;
    logic        core_start_o;
    logic [31:0] core_pc_o;
    // decode
    logic        cpu_valid_i   = 1'b0;
    logic [31:0] cpu_addr_i    = 32'h00000000;
    logic        flash_sel_o;
    logic        sram_sel_o;
    logic        abort_o;
    logic [14:0] mem_off_o;
    logic [5:0]  page_o;
    // command engine
    logic        cmd_req_i     = 1'b0;
    logic        cmd_ew_i      = 1'b0;
    logic        ctrl_busy_i   = 1'b0;
    logic        cmd_done_i    = 1'b0;
    logic        cmd_pass_i    = 1'b0;
    logic        cmd_go_o;
    logic        flash_irq_o;

    int err_count = 0;
    int cmp_count = 0;

    always #20 clk_i = ~clk_i;

    frc_remap_status u_dut (
        .clk_i(clk_i), .srst_i(srst_i),
        .reg_req_i(reg_req_i), .reg_we_i(reg_we_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
        .kernel_done_i(kernel_done_i), .kernel_run_o(kernel_run_o),
        .core_start_o(core_start_o), .core_pc_o(core_pc_o),
        .cpu_valid_i(cpu_valid_i), .cpu_addr_i(cpu_addr_i),
        .flash_sel_o(flash_sel_o), .sram_sel_o(sram_sel_o),
        .abort_o(abort_o), .mem_off_o(mem_off_o), .page_o(page_o),
        .cmd_req_i(cmd_req_i), .cmd_ew_i(cmd_ew_i),
        .ctrl_busy_i(ctrl_busy_i), .cmd_done_i(cmd_done_i),
        .cmd_pass_i(cmd_pass_i), .cmd_go_o(cmd_go_o),
        .flash_irq_o(flash_irq_o)
    );

    task automatic end_sim;
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic bit1(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : bit1

    // one register access; a miss must give no ack and zero data
    task automatic acc(input logic we, input logic [31:0] a,
                       input logic [31:0] d, input logic ack);
        @(posedge clk_i);
        reg_req_i   <= 1'b1;
        reg_we_i    <= we;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_req_i <= 1'b0;
        reg_we_i  <= 1'b0;
        #1;
        bit1(reg_ack_o, ack);
        if (!we) chk(reg_rdata_o, d);
    endtask : acc

    // one core access; offset and page only looked at on a hit
    task automatic mem(input logic [31:0] a, input logic f, input logic s,
                       input logic ab, input logic [14:0] off);
        @(posedge clk_i);
        cpu_valid_i <= 1'b1;
        cpu_addr_i  <= a;
        @(posedge clk_i);
        cpu_valid_i <= 1'b0;
        #1;
        chk({29'h0, flash_sel_o, sram_sel_o, abort_o}, {29'h0, f, s, ab});
        if (f || s) begin
            chk({17'h0, mem_off_o}, {17'h0, off});
            chk({26'h0, page_o}, {26'h0, off[14:9]});
        end
    endtask : mem

    task automatic cmd(input logic ew, input logic go);
        @(posedge clk_i);
        cmd_req_i <= 1'b1;
        cmd_ew_i  <= ew;
        @(posedge clk_i);
        cmd_req_i <= 1'b0;
        #1;
        bit1(cmd_go_o, go);
    endtask : cmd

    // irq output lags the flag by one cycle
    task automatic done(input logic ok, input logic irq);
        @(posedge clk_i);
        cmd_done_i <= 1'b1;
        cmd_pass_i <= ok;
        @(posedge clk_i);
        cmd_done_i <= 1'b0;
        @(posedge clk_i);
        #1;
        bit1(flash_irq_o, irq);
    endtask : done

    task automatic t_reset;
        #1;
        bit1(kernel_run_o, 1'b1);
        chk(core_pc_o, 32'h00000000);
        acc(1'b0, frc_pkg::REMAP_ADDR, 32'h00000000, 1'b1);
        acc(1'b0, frc_pkg::MOD_ADDR, 32'h00000000, 1'b1);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000020, 1'b1);
        acc(1'b0, 32'hffff0224, 32'h00000000, 1'b0);
    endtask : t_reset

    task automatic t_boot;
        mem(32'h00087800, 1'b1, 1'b0, 1'b0, 15'h7800);
        @(posedge clk_i);
        kernel_done_i <= 1'b1;
        @(posedge clk_i);
        kernel_done_i <= 1'b0;
        #1;
        bit1(kernel_run_o, 1'b0);
        bit1(core_start_o, 1'b0);
        @(posedge clk_i);
        #1;
        bit1(core_start_o, 1'b1);
        @(posedge clk_i);
        kernel_done_i <= 1'b1;
        #1;
        bit1(core_start_o, 1'b0);
        @(posedge clk_i);
        kernel_done_i <= 1'b0;
        repeat (3) begin
            @(posedge clk_i);
            #1;
            bit1(core_start_o, 1'b0);
        end
        mem(32'h00087800, 1'b0, 1'b0, 1'b1, 15'h0);
    endtask : t_boot

    task automatic t_map;
        mem(32'h00000010, 1'b1, 1'b0, 1'b0, 15'h0010);
        mem(32'h000801ff, 1'b1, 1'b0, 1'b0, 15'h01ff);
        mem(32'h00080200, 1'b1, 1'b0, 1'b0, 15'h0200);
        // remap only from the absolute flash copy, upper bits zero
        acc(1'b1, frc_pkg::REMAP_ADDR, 32'h00000001, 1'b1);
        acc(1'b0, frc_pkg::REMAP_ADDR, 32'h00000001, 1'b1);
        mem(32'h00000010, 1'b0, 1'b1, 1'b0, 15'h0010);
        mem(32'h00000ffc, 1'b0, 1'b1, 1'b0, 15'h0ffc);
        mem(32'h00001000, 1'b0, 1'b0, 1'b1, 15'h0);
        mem(32'h00080010, 1'b1, 1'b0, 1'b0, 15'h0010);
        mem(32'hffff0220, 1'b0, 1'b0, 1'b0, 15'h0);
        mem(32'h00100000, 1'b0, 1'b0, 1'b1, 15'h0);
        acc(1'b1, frc_pkg::REMAP_ADDR, 32'h00000000, 1'b1);
        mem(32'h00000010, 1'b1, 1'b0, 1'b0, 15'h0010);
    endtask : t_map

    task automatic t_cmd;
        acc(1'b1, frc_pkg::MOD_ADDR, 32'h00000100, 1'b1);
        cmd(1'b1, 1'b0);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000022, 1'b1);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000020, 1'b1);
        cmd(1'b0, 1'b1);
        acc(1'b1, frc_pkg::MOD_ADDR, 32'h00000108, 1'b1);
        acc(1'b0, frc_pkg::MOD_ADDR, 32'h00000108, 1'b1);
        cmd(1'b1, 1'b1);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000020, 1'b1);
    endtask : t_cmd

    task automatic t_done;
        acc(1'b1, frc_pkg::MOD_ADDR, 32'h00000118, 1'b1);
        done(1'b1, 1'b1);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000029, 1'b1);
        repeat (2) @(posedge clk_i);
        #1;
        bit1(flash_irq_o, 1'b0);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000020, 1'b1);
        acc(1'b1, frc_pkg::MOD_ADDR, 32'h00000108, 1'b1);
        done(1'b0, 1'b0);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000022, 1'b1);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000020, 1'b1);
    endtask : t_done

    task automatic t_busy;
        @(posedge clk_i);
        ctrl_busy_i <= 1'b1;
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000024, 1'b1);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000024, 1'b1);
        @(posedge clk_i);
        ctrl_busy_i <= 1'b0;
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000020, 1'b1);
    endtask : t_busy

    // a write must neither clear pass nor set fail or irq
    task automatic t_wrsta;
        done(1'b1, 1'b0);
        acc(1'b1, frc_pkg::STA_ADDR, 32'h0000000a, 1'b1);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000021, 1'b1);
    endtask : t_wrsta

    task automatic t_rst;
        acc(1'b1, frc_pkg::REMAP_ADDR, 32'h00000001, 1'b1);
        acc(1'b1, frc_pkg::MOD_ADDR, 32'h00000118, 1'b1);
        done(1'b1, 1'b1);
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        bit1(kernel_run_o, 1'b1);
        acc(1'b0, frc_pkg::REMAP_ADDR, 32'h00000000, 1'b1);
        acc(1'b0, frc_pkg::MOD_ADDR, 32'h00000000, 1'b1);
        acc(1'b0, frc_pkg::STA_ADDR, 32'h00000020, 1'b1);
        bit1(flash_irq_o, 1'b0);
        mem(32'h00000010, 1'b1, 1'b0, 1'b0, 15'h0010);
    endtask : t_rst

    // whole run is about 120 cycles
    initial begin
        #(40 * 3000);
        err_count++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_boot();
        t_map();
        t_cmd();
        t_done();
        t_busy();
        t_wrsta();
        t_rst();
        end_sim();
    end
endmodule : frc_remap_status_bench

`default_nettype wire
